// file: lrx_regs.svh
// Register offsets, field positions and reset values of the receive output block
`ifndef LRX_REGS_SVH
`define LRX_REGS_SVH

`define LRX_OFF_CTRL     12'h000
`define LRX_OFF_STATUS   12'h004
`define LRX_OFF_IRQ_STAT 12'h008
`define LRX_OFF_IRQ_MASK 12'h00c

`define LRX_CTRL_W       5
`define LRX_CTRL_RST     5'h00
`define LRX_STATUS_W     3
`define LRX_IRQ_W        2
`define LRX_IRQ_RST      2'h0

`define LRX_STAT_LOS     0
`define LRX_STAT_HW      1
`define LRX_STAT_CS      2

`endif

// file: lrx_pkg.sv
// Types shared by the receive output block
package lrx_pkg;

  // Receive outputs toward the framer
  typedef struct packed {
    logic los;
    logic neg;
    logic pos;
  } lrx_rx_bits_t;

  // Control register layout, bit 4 first
  typedef struct packed {
    logic edge_fall;
    logic mute;
    logic ami;
    logic single_rail;
    logic global_irq_enable;
  } lrx_ctrl_t;

  // Interrupt status and mask layout
  typedef struct packed {
    logic cv;
    logic los;
  } lrx_irq_t;

endpackage

// file: lrx_sync.sv
// Two-stage synchroniser for inputs from outside the pclk domain
`timescale 1ns/10ps
module lrx_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // lrx_sync

// file: lrx_top.sv
// Receive data outputs, mode selection, shared host pins and alarm interrupt
//
// Function
// - High or floating mode pin selects hardware mode
// - Host mode: write data in, read data out
// - Host mode: interrupt pin pulled low on alarm
// - Global enable cleared blocks the interrupt pin; irq output still follows status and mask
// - Interrupt pin is open drain, pulls low only
// - Hardware mode: five serial pins become equalizer control
// - Loss flag high at least one receive cycle
// - Loss flag stays high while loss persists
// - Dual rail: positive and negative data separate
// - Single rail: NRZ data on positive pin
// - Single rail: negative pin pulses per violation
// - AMI with single rail: every bipolar violation outside a muted loss gives a negative pin pulse
// - Mute forces data outputs low during loss
// - Edge select chooses falling or rising update
// - Unconnected mute input reads low, mute off
`timescale 1ns/10ps
`include "lrx_regs.svh"
module lrx_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  input  wire logic              control_mode_select,
  input  wire logic              serial_write_input,
  input  wire logic              serial_clock,
  input  wire logic              chip_select_n,
  input  wire logic              equalizer_ctrl_bit3,
  output logic                   serial_read_output,
  output logic                   serial_read_output_oe,
  input  wire logic              equalizer_ctrl_bit0,
  output logic                   irq_pin_out,
  output logic                   irq_pin_oe,
  output logic                   host_write_data,
  output logic                   host_serial_clock,
  output logic                   host_chip_select_n,
  input  wire logic              host_read_data,
  output logic      [4:0]        equalizer_ctrl,
  input  wire logic              rx_clock,
  input  wire logic              rec_pos,
  input  wire logic              rec_neg,
  input  wire logic              los_detect,
  input  wire logic              rx_output_mute,
  input  wire logic              rx_output_edge_select,
  output logic                   rx_positive_rail,
  output logic                   rx_negative_rail,
  output logic                   rx_signal_loss_flag
);

  // ==========================================================
  // Input synchronisers
  localparam int NSYNC = 12;

  logic [NSYNC-1:0] pins_s;

  lrx_sync #(.W(NSYNC)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    // Idle-high pins pass inverted, so a synchroniser in reset reads them idle
    .async_in ({rx_clock, rec_pos, rec_neg, los_detect,
                !control_mode_select, rx_output_mute,
                rx_output_edge_select, serial_write_input,
                equalizer_ctrl_bit3, serial_clock, !chip_select_n,
                equalizer_ctrl_bit0}),
    .sync_out (pins_s)
  );

  wire logic       rclk_s   = pins_s[11];
  wire logic       pos_s    = pins_s[10];
  wire logic       neg_s    = pins_s[9];
  wire logic       los_s    = pins_s[8];
  wire logic       mode_s   = !pins_s[7];
  wire logic       mute_s   = pins_s[6];
  wire logic       edge_s   = pins_s[5];
  wire logic [4:0] shared_s = {pins_s[4:2], !pins_s[1], pins_s[0]};

  // ==========================================================
  // Mode and shared pins
  logic hw_mode;
  logic sdo_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_mode <= 1'b1;
    end else begin
      hw_mode <= mode_s;
    end
  end

  // Host-mode chip select; held inactive in hardware mode
  wire logic cs_act = !hw_mode && !shared_s[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_write_data    <= 1'b0;
      host_serial_clock  <= 1'b0;
      host_chip_select_n <= 1'b1;
      equalizer_ctrl     <= 5'h00;
      sdo_q              <= 1'b0;
    end else begin
      host_write_data    <= !hw_mode && shared_s[4];
      host_serial_clock  <= !hw_mode && shared_s[2];
      host_chip_select_n <= !cs_act;
      sdo_q              <= host_read_data;
      // Pins 21..25 in order carry bits 4..0
      if (hw_mode) begin
        equalizer_ctrl <= shared_s;
      end
    end
  end

  // Read data pin drives only while a host transfer is open
  assign serial_read_output    = sdo_q;
  assign serial_read_output_oe = cs_act;

  // ==========================================================
  // APB register file
  lrx_pkg::lrx_ctrl_t ctrl;
  lrx_pkg::lrx_irq_t  irq_stat;
  lrx_pkg::lrx_irq_t  irq_mask;
  lrx_pkg::lrx_irq_t  irq_ev;

  wire logic sel_ctrl  = paddr == ADDR_W'(`LRX_OFF_CTRL);
  wire logic sel_stat  = paddr == ADDR_W'(`LRX_OFF_STATUS);
  wire logic sel_istat = paddr == ADDR_W'(`LRX_OFF_IRQ_STAT);
  wire logic sel_imask = paddr == ADDR_W'(`LRX_OFF_IRQ_MASK);
  wire logic mapped    = sel_ctrl | sel_stat | sel_istat | sel_imask;
  wire logic setup     = psel && !penable;
  wire logic access    = psel && penable;
  wire logic wr_ok     = access && pwrite && mapped;

  logic [`LRX_STATUS_W-1:0] status_v;
  logic [31:0]              rd_mux;

  assign status_v[`LRX_STAT_LOS] = rx_signal_loss_flag;
  assign status_v[`LRX_STAT_HW]  = hw_mode;
  assign status_v[`LRX_STAT_CS]  = cs_act;

  assign rd_mux = sel_ctrl  ? 32'(ctrl)     :
                  sel_stat  ? 32'(status_v) :
                  sel_istat ? 32'(irq_stat) :
                  sel_imask ? 32'(irq_mask) : 32'h0000_0000;

  // Zero wait states: read data is caught in the setup cycle
  assign pready  = access;
  assign pslverr = access && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `LRX_CTRL_RST;
      irq_mask <= `LRX_IRQ_RST;
    end else if (wr_ok) begin
      if (sel_ctrl) begin
        ctrl <= pwdata[`LRX_CTRL_W-1:0];
      end
      if (sel_imask) begin
        irq_mask <= pwdata[`LRX_IRQ_W-1:0];
      end
    end
  end

  // Write one to clear; a new event in the same cycle wins
  wire logic [`LRX_IRQ_W-1:0] w1c =
    (wr_ok && sel_istat) ? pwdata[`LRX_IRQ_W-1:0] : `LRX_IRQ_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= `LRX_IRQ_RST;
    end else begin
      irq_stat <= (irq_stat & ~w1c) | irq_ev;
    end
  end

  wire logic irq_any = |(irq_stat & irq_mask);
  assign irq = irq_any;

  // Open drain: output level is always low, only the enable moves
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe  = !hw_mode && ctrl.global_irq_enable && irq_any;

  // ==========================================================
  // Receive clock edge and output update
  logic rclk_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= rclk_s;
    end
  end

  // In host mode the register supplies mute and edge choice
  wire logic edge_eff = hw_mode ? edge_s : ctrl.edge_fall;
  wire logic mute_eff = hw_mode ? mute_s : ctrl.mute;
  wire logic rise_ev  = rclk_s && !rclk_q;
  wire logic fall_ev  = !rclk_s && rclk_q;
  wire logic upd      = edge_eff ? fall_ev : rise_ev;

  // ==========================================================
  // Code violation detection
  logic last_neg;
  logic seen_mark;

  wire logic mark    = pos_s ^ neg_s;
  wire logic both    = pos_s && neg_s;
  wire logic bpv     = mark && seen_mark && (neg_s == last_neg);
  // Substitution codes are decoded upstream, so only AMI checks polarity
  wire logic cv      = both || (ctrl.ami && bpv);
  wire logic muted   = mute_eff && los_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_neg  <= 1'b0;
      seen_mark <= 1'b0;
    end else if (upd && mark) begin
      last_neg  <= neg_s;
      seen_mark <= 1'b1;
    end
  end

  lrx_pkg::lrx_rx_bits_t rx_q;
  lrx_pkg::lrx_rx_bits_t next_rx;

  always_comb begin
    next_rx.los = los_s;
    if (muted) begin
      next_rx.pos = 1'b0;
      next_rx.neg = 1'b0;
    end else if (ctrl.single_rail) begin
      next_rx.pos = pos_s || neg_s;
      next_rx.neg = cv;
    end else begin
      next_rx.pos = pos_s;
      next_rx.neg = neg_s;
    end
  end

  // Flags and data share one update edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= '0;
    end else if (upd) begin
      rx_q <= next_rx;
    end
  end

  assign rx_positive_rail    = rx_q.pos;
  assign rx_negative_rail    = rx_q.neg;
  assign rx_signal_loss_flag = rx_q.los;

  assign irq_ev.los = upd && los_s && !rx_q.los;
  assign irq_ev.cv  = upd && ctrl.single_rail && !muted && cv;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rise;
    !rclk_s ##1 rclk_s;
  endsequence

  sequence s_fall;
    rclk_s ##1 !rclk_s;
  endsequence

  AST_HW_MODE:
    assert property (!mode_s |=> !hw_mode)
    else $error("low mode pin did not select host mode");

  AST_SDO_OE:
    assert property (serial_read_output_oe |-> !hw_mode ##1 !host_chip_select_n)
    else $error("read pin driven outside a host transfer");

  AST_INT_PULL:
    assert property (!hw_mode && ctrl.global_irq_enable && |(irq_stat & irq_mask) |-> irq_pin_oe)
    else $error("alarm did not pull interrupt pin");

  AST_GIE_OFF:
    assert property (!ctrl.global_irq_enable |-> !irq_pin_oe)
    else $error("interrupt pin active with global enable off");

  AST_OPEN_DRAIN:
    assert property (irq_pin_oe |-> !irq_pin_out)
    else $error("interrupt pin driven high");

  AST_EQ_HOLD:
    assert property (!hw_mode |=> $stable(equalizer_ctrl))
    else $error("equalizer bits moved in host mode");

  AST_LOS_SET:
    assert property (upd && los_s |=> rx_signal_loss_flag)
    else $error("loss flag not raised on update");

  AST_LOS_HOLD:
    assert property (rx_signal_loss_flag && !upd |=> rx_signal_loss_flag)
    else $error("loss flag dropped between updates");

  AST_STABLE:
    assert property (!upd |=> $stable(rx_q))
    else $error("receive outputs changed off the update edge");

  AST_MUTE:
    assert property (upd && los_s && mute_eff |=> !rx_positive_rail && !rx_negative_rail)
    else $error("data not muted during loss");

  AST_BPV:
    assert property (upd && ctrl.single_rail && ctrl.ami && bpv && !muted
                     |=> rx_negative_rail)
    else $error("bipolar violation gave no pulse");

  AST_EDGE_RISE:
    assert property (s_rise ##0 !edge_eff |-> upd)
    else $error("rising edge missed");

  AST_EDGE_FALL:
    assert property (s_fall ##0 edge_eff |-> upd)
    else $error("falling edge missed");

endmodule // lrx_top

// file: lrx_line_model.sv
// Line-side source model: recovered receive clock, rail data and loss level
`timescale 1ns/10ps
module lrx_line_model (
  input  wire logic nxt_pos,
  input  wire logic nxt_neg,
  input  wire logic nxt_los,
  output logic      rx_clock,
  output logic      rec_pos,
  output logic      rec_neg,
  output logic      los_detect
);
  // ========
  // Recovered clock runs free, as a real recovered clock does
  initial begin
    rx_clock = 1'b0;
    rec_pos = 1'b0;
    rec_neg = 1'b0;
    los_detect = 1'b0;
    forever #62.5 rx_clock = ~rx_clock;
  end
  // ========
  // Data move a quarter period after the rise, so either update edge sees settled rails
  always @(posedge rx_clock) begin
    #31;
    rec_pos = nxt_pos;
    rec_neg = nxt_neg;
    los_detect = nxt_los;
  end
endmodule // lrx_line_model

// file: line_receiver_output_and_alarm_pins_tb.sv
// Self-checking bench of the receive output block
`timescale 1ns/10ps
`include "lrx_regs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module line_receiver_output_and_alarm_pins_tb;
  logic        pclk, presetn, psel, penable, pwrite, control_mode_select;
  logic        serial_write_input, serial_clock, chip_select_n, host_read_data;
  logic        rx_output_mute, rx_output_edge_select, eq3_drv, eq0_drv, np, nn, nl, efall;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdv;
  logic        erv;
  int          err_total, check_count;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, serial_read_output, serial_read_output_oe;
  wire         irq_pin_out, irq_pin_oe, host_write_data, host_serial_clock;
  wire         host_chip_select_n, rx_clock, rec_pos, rec_neg, los_detect;
  wire         rx_positive_rail, rx_negative_rail, rx_signal_loss_flag;
  wire  [4:0]  equalizer_ctrl;
  // Shared pins: eq0_drv stands for the pull-up while nobody else drives
  wire         equalizer_ctrl_bit3 = serial_read_output_oe ? serial_read_output : eq3_drv;
  wire         equalizer_ctrl_bit0 = irq_pin_oe ? irq_pin_out : eq0_drv;
  lrx_pkg::lrx_rx_bits_t rxo;
  assign rxo = {rx_signal_loss_flag, rx_negative_rail, rx_positive_rail};

  lrx_top DUT (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .irq, .control_mode_select, .serial_write_input, .serial_clock,
    .chip_select_n, .equalizer_ctrl_bit3, .serial_read_output, .serial_read_output_oe,
    .equalizer_ctrl_bit0, .irq_pin_out, .irq_pin_oe, .host_write_data,
    .host_serial_clock, .host_chip_select_n, .host_read_data, .equalizer_ctrl,
    .rx_clock, .rec_pos, .rec_neg, .los_detect, .rx_output_mute,
    .rx_output_edge_select, .rx_positive_rail, .rx_negative_rail, .rx_signal_loss_flag
  );
  lrx_line_model line_src (
    .nxt_pos(np), .nxt_neg(nn), .nxt_los(nl), .rx_clock, .rec_pos, .rec_neg, .los_detect
  );

  // ========
  // Bus and link tasks
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends when pready is seen; the watchdog ends it only if pready never comes
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdv, erv);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    begin
      apb(1'b0, a, 32'h0, rdv, erv);
      `CHK(rdv, x)
    end
  endtask
  task settle(input int n);
    begin
      repeat (n) @(posedge pclk);
      #1;
    end
  endtask
  // Symbol s = {loss, neg, pos}; e is the expected {flag, neg, pos} after the update edge
  task sym(input logic [2:0] s, input logic [2:0] e);
    begin
      @(posedge rx_clock);
      #1;
      {nl, nn, np} = s;
      if (efall) @(negedge rx_clock);
      else @(posedge rx_clock);
      #24;
      `CHK(rxo, e)
    end
  endtask

  // ========
  // Scenarios
  task t_regs;
    begin
      rd(`LRX_OFF_CTRL, 32'h0);
      rd(`LRX_OFF_IRQ_MASK, 32'h0);
      rd(`LRX_OFF_STATUS, 32'h2);
      wr(`LRX_OFF_CTRL, 32'hffffffff);
      rd(`LRX_OFF_CTRL, 32'h1f);
      wr(`LRX_OFF_CTRL, 32'h0);
      apb(1'b0, 12'h010, 32'h0, rdv, erv);
      `CHK({erv, rdv}, 33'h100000000)
    end
  endtask
  task t_rails;
    begin
      sym(3'b001, 3'b001);
      sym(3'b010, 3'b010);
      sym(3'b011, 3'b011);
      wr(`LRX_OFF_CTRL, 32'h2);
      sym(3'b010, 3'b001);
      sym(3'b011, 3'b011);
      sym(3'b001, 3'b001);
      sym(3'b001, 3'b001);
      sym(3'b000, 3'b000);
      wr(`LRX_OFF_CTRL, 32'h6);
      sym(3'b010, 3'b001);
      sym(3'b001, 3'b001);
      sym(3'b001, 3'b011);
      sym(3'b000, 3'b000);
      wr(`LRX_OFF_CTRL, 32'h0);
    end
  endtask
  task t_edge_los;
    begin
      @(posedge pclk);
      rx_output_edge_select <= 1'b1;
      efall = 1'b1;
      sym(3'b001, 3'b001);
      sym(3'b110, 3'b110);
      sym(3'b000, 3'b000);
      @(posedge pclk);
      rx_output_edge_select <= 1'b0;
      efall = 1'b0;
      sym(3'b101, 3'b101);
      sym(3'b101, 3'b101);
      @(posedge pclk);
      rx_output_mute <= 1'b1;
      sym(3'b101, 3'b100);
      sym(3'b000, 3'b000);
      sym(3'b100, 3'b100);
      sym(3'b001, 3'b001);
      @(posedge pclk);
      rx_output_mute <= 1'b0;
    end
  endtask
  task t_irq;
    begin
      rd(`LRX_OFF_IRQ_STAT, 32'h3);
      `CHK(irq, 1'b0)
      wr(`LRX_OFF_IRQ_MASK, 32'h3);
      settle(2);
      `CHK({irq, irq_pin_oe}, 2'b10)
      @(posedge pclk);
      control_mode_select <= 1'b0;
      settle(8);
      `CHK(irq_pin_oe, 1'b0)
      wr(`LRX_OFF_CTRL, 32'h1);
      settle(2);
      `CHK({irq_pin_oe, irq_pin_out, equalizer_ctrl_bit0}, 3'b100)
      wr(`LRX_OFF_IRQ_STAT, 32'h1);
      rd(`LRX_OFF_IRQ_STAT, 32'h2);
      wr(`LRX_OFF_IRQ_MASK, 32'h1);
      settle(2);
      `CHK({irq, irq_pin_oe, equalizer_ctrl_bit0}, 3'b001)
    end
  endtask
  task t_host;
    begin
      @(posedge pclk);
      serial_write_input <= 1'b1;
      serial_clock <= 1'b1;
      chip_select_n <= 1'b0;
      host_read_data <= 1'b1;
      settle(6);
      `CHK({host_write_data, host_serial_clock, host_chip_select_n}, 3'b110)
      `CHK({serial_read_output_oe, equalizer_ctrl_bit3}, 2'b11)
      `CHK(equalizer_ctrl, 5'h03)
      @(posedge pclk);
      host_read_data <= 1'b0;
      settle(2);
      `CHK(equalizer_ctrl_bit3, 1'b0)
      rd(`LRX_OFF_STATUS, 32'h4);
      @(posedge pclk);
      chip_select_n <= 1'b1;
      settle(6);
      `CHK({host_chip_select_n, serial_read_output_oe}, 2'b10)
      @(posedge pclk);
      chip_select_n <= 1'b0;
      control_mode_select <= 1'b1;
      settle(8);
      `CHK(equalizer_ctrl, 5'h15)
      `CHK({host_write_data, host_serial_clock, host_chip_select_n}, 3'b001)
      `CHK({serial_read_output_oe, irq_pin_oe}, 2'b00)
    end
  endtask

  // ========
  // Run control
  task wrap_up;
    begin
      if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {serial_write_input, serial_clock, host_read_data, eq3_drv} = '0;
    {rx_output_mute, rx_output_edge_select, np, nn, nl, efall} = '0;
    {control_mode_select, chip_select_n, eq0_drv} = 3'b111;
    err_total = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs;
    t_rails;
    t_edge_los;
    t_irq;
    t_host;
    wrap_up;
  end
  // Whole run takes a few microseconds; this bound only catches a hang
  initial begin
    #200000;
    err_total++;
    wrap_up;
  end
endmodule // line_receiver_output_and_alarm_pins_tb
